// [rtl/cbbc_pkg.sv]
package cbbc_pkg;
	localparam int PC_W    = 21;
	localparam int DADDR_W = 12;
	localparam int AXI_A_W = 8;
	localparam int AXI_D_W = 32;

	// Access bank: low file addresses in bank 0, the rest in the top bank
	localparam logic [7:0] ACC_SPLIT_DEF = 8'h80;
	localparam logic [3:0] ACC_LOW_BANK  = 4'h0;
	localparam logic [3:0] ACC_HIGH_BANK = 4'hf;

	localparam logic [PC_W-1:0] PC_RST      = 21'h000000;
	localparam logic [PC_W-1:0] PC_STEP     = 21'h000002;
	localparam logic [PC_W-1:0] CALL_RET_STEP = 21'h000004;

	// Opcode patterns, compared on the bits that the mask keeps; watchdog clear on the whole word
	localparam logic [15:0] MASK_TOGGLE = 16'hf000;
	localparam logic [15:0] CODE_TOGGLE = 16'h7000;
	localparam logic [15:0] MASK_BRANCH = 16'hff00;
	localparam logic [15:0] CODE_BOV    = 16'he400;
	localparam logic [15:0] CODE_BZ     = 16'he000;
	localparam logic [15:0] MASK_CALL   = 16'hfe00;
	localparam logic [15:0] CODE_CALL   = 16'hec00;
	localparam logic [15:0] MASK_CLEAR  = 16'hfe00;
	localparam logic [15:0] CODE_CLEAR  = 16'h6a00;
	localparam logic [15:0] CODE_WDT    = 16'h0004;
	localparam int BIT_ACCESS = 8;
	localparam int BIT_FAST   = 8;
	localparam logic [7:0] CLEAR_VALUE = 8'h00;

	// Register map
	localparam logic [AXI_A_W-1:0] REG_CTRL_OFS   = 8'h00;
	localparam logic [AXI_A_W-1:0] REG_PC_OFS     = 8'h04;
	localparam logic [AXI_A_W-1:0] REG_INSTR_OFS  = 8'h08;
	localparam logic [AXI_A_W-1:0] REG_RETIRE_OFS = 8'h0c;
	localparam int CTRL_RUN_BIT = 0;
	localparam logic CTRL_RUN_RST = 1'b1;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		PH_Q1 = 4'b0001,
		PH_Q2 = 4'b0010,
		PH_Q3 = 4'b0100,
		PH_Q4 = 4'b1000
	} cbbc_phase_e;

	typedef enum logic [6:0] {
		OP_NONE        = 7'b0000001,
		OP_BIT_TOGGLE  = 7'b0000010,
		OP_BRANCH_OV   = 7'b0000100,
		OP_BRANCH_ZERO = 7'b0001000,
		OP_CALL        = 7'b0010000,
		OP_REG_CLEAR   = 7'b0100000,
		OP_WDT_CLEAR   = 7'b1000000
	} cbbc_op_e;

	typedef struct packed {
		logic [DADDR_W-1:0] addr;
		logic [7:0]         wdata;
		logic               rd_en;
		logic               wr_en;
	} cbbc_dmem_s;

	typedef struct packed {
		logic [PC_W-1:0] pc;
		logic [15:0]     instr;
		logic [31:0]     retired;
	} cbbc_stat_s;
endpackage

// [rtl/cbbc_axil_regs.sv]
`timescale 1ns/1ps
module cbbc_axil_regs import cbbc_pkg::*; (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [AXI_A_W-1:0] awaddr,
	input  wire logic               awvalid,
	output logic                    awready,
	input  wire logic [AXI_D_W-1:0] wdata,
	input  wire logic [3:0]         wstrb,
	input  wire logic               wvalid,
	output logic                    wready,
	output logic [1:0]              bresp,
	output logic                    bvalid,
	input  wire logic               bready,
	input  wire logic [AXI_A_W-1:0] araddr,
	input  wire logic               arvalid,
	output logic                    arready,
	output logic [AXI_D_W-1:0]      rdata,
	output logic [1:0]              rresp,
	output logic                    rvalid,
	input  wire logic               rready,
	input  wire cbbc_stat_s         core_stat,
	output logic                    run
);
	logic               aw_ff, nxt_aw, w_ff, nxt_w, strb_ff, nxt_strb;
	logic [AXI_A_W-1:0] awaddr_ff, nxt_awaddr;
	logic [AXI_D_W-1:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
	logic               bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid, ctrl_ff, nxt_ctrl;
	logic [1:0]         bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [AXI_A_W-1:0] wa, ra;

	assign awready = !aw_ff;
	assign wready  = !w_ff;
	assign arready = !rvalid_ff;
	assign bvalid  = bvalid_ff;
	assign bresp   = bresp_ff;
	assign rvalid  = rvalid_ff;
	assign rdata   = rdata_ff;
	assign rresp   = rresp_ff;
	assign run     = ctrl_ff;

	//////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_aw = aw_ff;
		nxt_w = w_ff;
		nxt_strb = strb_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata = wdata_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_ctrl = ctrl_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		wa = {awaddr_ff[AXI_A_W-1:2], 2'b00};
		ra = {araddr[AXI_A_W-1:2], 2'b00};
		if (awvalid && !aw_ff) begin
			nxt_aw = 1'b1;
			nxt_awaddr = awaddr;
		end
		if (wvalid && !w_ff) begin
			nxt_w = 1'b1;
			nxt_wdata = wdata;
			nxt_strb = wstrb[0];
		end
		if (bvalid_ff && bready)
			nxt_bvalid = 1'b0;
		// Address and data may arrive in either order; act once both are held
		if (aw_ff && w_ff && !bvalid_ff) begin
			nxt_aw = 1'b0;
			nxt_w = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = RESP_OKAY;
			if (wa == REG_CTRL_OFS) begin
				if (strb_ff)
					nxt_ctrl = wdata_ff[CTRL_RUN_BIT];
			end else if (wa != REG_PC_OFS && wa != REG_INSTR_OFS && wa != REG_RETIRE_OFS) begin
				nxt_bresp = RESP_SLVERR;
			end
		end
		if (rvalid_ff && rready)
			nxt_rvalid = 1'b0;
		if (arvalid && !rvalid_ff) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = RESP_OKAY;
			nxt_rdata = '0;
			unique case (ra)
				REG_CTRL_OFS:   nxt_rdata[CTRL_RUN_BIT] = ctrl_ff;
				REG_PC_OFS:     nxt_rdata[PC_W-1:0] = core_stat.pc;
				REG_INSTR_OFS:  nxt_rdata[15:0] = core_stat.instr;
				REG_RETIRE_OFS: nxt_rdata = core_stat.retired;
				default:        nxt_rresp = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			strb_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			ctrl_ff <= CTRL_RUN_RST;
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= RESP_OKAY;
		end else begin
			aw_ff <= nxt_aw;
			w_ff <= nxt_w;
			strb_ff <= nxt_strb;
			awaddr_ff <= nxt_awaddr;
			wdata_ff <= nxt_wdata;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			ctrl_ff <= nxt_ctrl;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end
endmodule

// [rtl/cbbc_core.sv]
`timescale 1ns/1ps
// Contract
// (RL1) Bit toggle inverts only the indexed bit of the addressed register; flags kept.
// (RL2) Access bit 0 uses the fixed access bank; 1 uses the bank select register.
// (RL3) Branch on overflow jumps only when the overflow flag is 1; flags kept.
// (RL4) Branch on zero jumps only when the zero flag is 1; flags kept.
// (RL5) Taken branch target is current address plus 2 plus twice the offset.
// (RL6) Untaken branch takes one cycle; taken takes two, PC written in Q4.
// (RL7) Call pushes current address plus 4, then loads target into PC bits 20..1.
// (RL8) Call with fast bit set copies working, status and bank select to shadows.
// (RL9) Call decodes from two words: 1110110s plus k low, then 1111 plus k high.
// (RL10) Call takes two cycles: push in Q3, high literal and PC write in Q4.
// (RL11) Register clear writes 00 to the addressed register and sets zero, one cycle.
// (RL12) Watchdog clear resets counter and postscaler, sets timeout and powerdown flags.
// (RL13) The prefetched word in a taken branch or call second cycle never executes.
module cbbc_core import cbbc_pkg::*; #(
	parameter logic [7:0] ACCESS_SPLIT = ACC_SPLIT_DEF
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [AXI_A_W-1:0] awaddr,
	input  wire logic               awvalid,
	output logic                    awready,
	input  wire logic [AXI_D_W-1:0] wdata,
	input  wire logic [3:0]         wstrb,
	input  wire logic               wvalid,
	output logic                    wready,
	output logic [1:0]              bresp,
	output logic                    bvalid,
	input  wire logic               bready,
	input  wire logic [AXI_A_W-1:0] araddr,
	input  wire logic               arvalid,
	output logic                    arready,
	output logic [AXI_D_W-1:0]      rdata,
	output logic [1:0]              rresp,
	output logic                    rvalid,
	input  wire logic               rready,
	output logic [PC_W-1:0]         prog_addr,
	input  wire logic [15:0]        prog_word,
	input  wire logic [15:0]        prog_word_next,
	output cbbc_dmem_s              dmem,
	input  wire logic [7:0]         dmem_rdata,
	input  wire logic [3:0]         bank_select_reg,
	input  wire logic               overflow_flag,
	input  wire logic               zero_flag,
	input  wire logic [7:0]         working_reg,
	input  wire logic [7:0]         status_reg,
	output logic                    zero_set,
	output logic [7:0]              working_shadow,
	output logic [7:0]              status_shadow,
	output logic [3:0]              bank_select_shadow,
	output logic                    stack_push,
	output logic [PC_W-1:0]         return_stack_top,
	output logic                    watchdog_clear,
	output logic                    timeout_flag_set,
	output logic                    powerdown_flag_set,
	output logic                    cycle_flushed
);
	cbbc_phase_e     phase_ff, nxt_phase;
	cbbc_op_e        op_ff, nxt_op;
	logic [15:0]     ir_ff, nxt_ir;
	logic [PC_W-1:0] pc_ff, nxt_pc;
	logic [PC_W-1:0] ret_ff, nxt_ret;
	logic [PC_W-1:0] branch_target;
	logic [7:0]      rdata_ff, nxt_rdata;
	logic            flush_ff, nxt_flush;
	logic            push_ff, nxt_push;
	logic            zero_ff, nxt_zero;
	logic            wdt_ff, nxt_wdt;
	logic [7:0]      ws_ff, nxt_ws, ss_ff, nxt_ss;
	logic [3:0]      bs_ff, nxt_bs;
	logic [31:0]     retired_ff, nxt_retired;
	cbbc_dmem_s      dmem_ff, nxt_dmem;
	cbbc_stat_s      stat;
	logic            run;
	logic            taken;
	logic [7:0]      toggle_mask;

	//////////////////////////////////////////////////////////////////////
	// Decode of the word at the current PC
	function automatic cbbc_op_e decode(input logic [15:0] w);
		cbbc_op_e op;
		op = OP_NONE;
		if ((w & MASK_TOGGLE) == CODE_TOGGLE)
			op = OP_BIT_TOGGLE; // [RL1]
		else if ((w & MASK_BRANCH) == CODE_BOV)
			op = OP_BRANCH_OV; // [RL3]
		else if ((w & MASK_BRANCH) == CODE_BZ)
			op = OP_BRANCH_ZERO; // [RL4]
		else if ((w & MASK_CALL) == CODE_CALL)
			op = OP_CALL; // [RL9]
		else if ((w & MASK_CLEAR) == CODE_CLEAR)
			op = OP_REG_CLEAR; // [RL11]
		else if (w == CODE_WDT)
			op = OP_WDT_CLEAR; // [RL12]
		return op;
	endfunction

	// File address: access bank split or bank select register
	function automatic logic [DADDR_W-1:0] file_addr(input logic [15:0] w,
		input logic [3:0] bank);
		logic [3:0] b;
		b = bank;
		if (!w[BIT_ACCESS])
			b = (w[7:0] < ACCESS_SPLIT) ? ACC_LOW_BANK : ACC_HIGH_BANK; // [RL2]
		return {b, w[7:0]};
	endfunction

	// One select line per data bit keeps the toggle a plain xor
	for (genvar i = 0; i < 8; i++) begin : g_toggle_sel
		assign toggle_mask[i] = (ir_ff[11:9] == 3'(i)); // [RL1]
	end

	//////////////////////////////////////////////////////////////////////
	// Offset doubled and sign-extended onto the word-aligned PC
	assign branch_target = pc_ff + PC_STEP + {{(PC_W-9){ir_ff[7]}}, ir_ff[7:0], 1'b0}; // [RL5]
	// Flags are read at the end of Q4, so a flag written earlier in the cycle counts
	assign taken = (op_ff == OP_BRANCH_OV && overflow_flag) // [RL3]
		|| (op_ff == OP_BRANCH_ZERO && zero_flag); // [RL4]

	always_comb begin
		nxt_phase = phase_ff;
		nxt_op = op_ff;
		nxt_ir = ir_ff;
		nxt_pc = pc_ff;
		nxt_ret = ret_ff;
		nxt_rdata = rdata_ff;
		nxt_flush = flush_ff;
		nxt_push = 1'b0;
		nxt_zero = 1'b0;
		nxt_wdt = 1'b0;
		nxt_dmem = dmem_ff;
		nxt_dmem.rd_en = 1'b0;
		nxt_dmem.wr_en = 1'b0;
		unique case (phase_ff)
			PH_Q1: begin
				// A stopped core parks between instructions, never mid-cycle
				if (run) begin
					nxt_phase = PH_Q2;
					nxt_ir = prog_word;
					nxt_op = flush_ff ? OP_NONE : decode(prog_word); // [RL13]
					// Bank select is read here for the address; a later change hits the next instruction, or the Q3 shadow copy of a fast call
					nxt_dmem.addr = file_addr(prog_word, bank_select_reg);
					if (!flush_ff && (decode(prog_word) == OP_BIT_TOGGLE
						|| decode(prog_word) == OP_REG_CLEAR))
						nxt_dmem.rd_en = 1'b1;
				end
			end
			PH_Q2: begin
				nxt_phase = PH_Q3;
				nxt_rdata = dmem_rdata;
				if (op_ff == OP_CALL) begin
					nxt_push = 1'b1; // [RL10]
					// Captured before the PC moves in Q4
					nxt_ret = pc_ff + CALL_RET_STEP; // [RL7]
				end
				if (op_ff == OP_WDT_CLEAR)
					nxt_wdt = 1'b1; // [RL12]
			end
			PH_Q3: begin
				nxt_phase = PH_Q4;
				if (op_ff == OP_BIT_TOGGLE) begin
					nxt_dmem.wdata = rdata_ff ^ toggle_mask; // [RL1]
					nxt_dmem.wr_en = 1'b1;
				end
				if (op_ff == OP_REG_CLEAR) begin
					nxt_dmem.wdata = CLEAR_VALUE; // [RL11]
					nxt_dmem.wr_en = 1'b1;
					nxt_zero = 1'b1; // [RL11]
				end
			end
			PH_Q4: begin
				nxt_phase = PH_Q1;
				if (flush_ff) begin
					// The discarded cycle leaves the PC on the target
					nxt_flush = 1'b0; // [RL13]
				end else begin
					nxt_pc = pc_ff + PC_STEP; // [RL6]
					if (taken) begin
						nxt_pc = branch_target; // [RL5]
						nxt_flush = 1'b1; // [RL6]
					end
					if (op_ff == OP_CALL) begin
						// Second word sits at PC+2 and is read here
						nxt_pc = {prog_word_next[11:0], ir_ff[7:0], 1'b0}; // [RL7] [RL9]
						nxt_flush = 1'b1; // [RL10]
					end
				end
			end
			default: nxt_phase = PH_Q1;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_ff <= PH_Q1;
			op_ff <= OP_NONE;
			ir_ff <= 16'h0000;
			pc_ff <= PC_RST;
			ret_ff <= PC_RST;
			rdata_ff <= 8'h00;
			flush_ff <= 1'b0;
			push_ff <= 1'b0;
			zero_ff <= 1'b0;
			wdt_ff <= 1'b0;
			dmem_ff <= '0;
		end else begin
			phase_ff <= nxt_phase;
			op_ff <= nxt_op;
			ir_ff <= nxt_ir;
			pc_ff <= nxt_pc;
			ret_ff <= nxt_ret;
			rdata_ff <= nxt_rdata;
			flush_ff <= nxt_flush;
			push_ff <= nxt_push;
			zero_ff <= nxt_zero;
			wdt_ff <= nxt_wdt;
			dmem_ff <= nxt_dmem;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Shadow copies move only on a fast call, kept apart from the sequencer
	always_comb begin
		nxt_ws = ws_ff;
		nxt_ss = ss_ff;
		nxt_bs = bs_ff;
		if (phase_ff == PH_Q3 && op_ff == OP_CALL && ir_ff[BIT_FAST]) begin
			nxt_ws = working_reg; // [RL8]
			nxt_ss = status_reg; // [RL8]
			nxt_bs = bank_select_reg; // [RL8]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ws_ff <= 8'h00;
			ss_ff <= 8'h00;
			bs_ff <= 4'h0;
		end else begin
			ws_ff <= nxt_ws;
			ss_ff <= nxt_ss;
			bs_ff <= nxt_bs;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Retire count: a discarded second cycle is not an instruction
	always_comb begin
		nxt_retired = retired_ff;
		if (phase_ff == PH_Q4 && !flush_ff)
			nxt_retired = retired_ff + 32'h00000001;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			retired_ff <= 32'h00000000;
		else
			retired_ff <= nxt_retired;
	end

	//////////////////////////////////////////////////////////////////////
	assign prog_addr          = pc_ff;
	assign dmem               = dmem_ff;
	assign zero_set           = zero_ff;
	assign working_shadow     = ws_ff;
	assign status_shadow      = ss_ff;
	assign bank_select_shadow = bs_ff;
	assign stack_push         = push_ff;
	assign return_stack_top   = ret_ff;
	assign watchdog_clear     = wdt_ff; // [RL12]
	assign timeout_flag_set   = wdt_ff; // [RL12]
	assign powerdown_flag_set = wdt_ff; // [RL12]
	assign cycle_flushed      = flush_ff;

	assign stat.pc      = pc_ff;
	assign stat.instr   = ir_ff;
	assign stat.retired = retired_ff;

	cbbc_axil_regs u_regs (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.awaddr    (awaddr),
		.awvalid   (awvalid),
		.awready   (awready),
		.wdata     (wdata),
		.wstrb     (wstrb),
		.wvalid    (wvalid),
		.wready    (wready),
		.bresp     (bresp),
		.bvalid    (bvalid),
		.bready    (bready),
		.araddr    (araddr),
		.arvalid   (arvalid),
		.arready   (arready),
		.rdata     (rdata),
		.rresp     (rresp),
		.rvalid    (rvalid),
		.rready    (rready),
		.core_stat (stat),
		.run       (run)
	);
endmodule

// [testbench/cbbc_core_checker.sv]
`timescale 1ns/1ps
module cbbc_core_checker import cbbc_pkg::*; #(
	parameter logic [7:0] ACCESS_SPLIT = ACC_SPLIT_DEF
) (
	input wire logic            aclk,
	input wire logic            aresetn,
	input wire logic [PC_W-1:0] prog_addr,
	input wire logic [15:0]     prog_word,
	input wire cbbc_dmem_s      dmem,
	input wire logic [7:0]      dmem_rdata,
	input wire logic [3:0]      bank_select_reg,
	input wire logic [7:0]      working_reg,
	input wire logic [7:0]      status_reg,
	input wire logic            zero_set,
	input wire logic [7:0]      working_shadow,
	input wire logic [7:0]      status_shadow,
	input wire logic [3:0]      bank_select_shadow,
	input wire logic            stack_push,
	input wire logic [PC_W-1:0] return_stack_top,
	input wire logic            watchdog_clear,
	input wire logic            timeout_flag_set,
	input wire logic            powerdown_flag_set,
	input wire logic            cycle_flushed
);
	logic [7:0] rd_ff;
	logic [7:0] nxt_rd;
	logic [3:0] bank;
	// Keeps the Q2 read so the Q4 write can be compared with it
	always_comb begin
		nxt_rd = dmem.rd_en ? dmem_rdata : rd_ff;
		bank   = prog_word[BIT_ACCESS] ? bank_select_reg :
			(prog_word[7:0] < ACCESS_SPLIT) ? ACC_LOW_BANK : ACC_HIGH_BANK;
	end
	always_ff @(posedge aclk) begin
		rd_ff <= nxt_rd;
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_bank_pick: assert property (dmem.rd_en |-> dmem.addr == {bank, prog_word[7:0]})
		else $error("data address bank wrong");
	a_read_write: assert property (dmem.rd_en |-> ##2 dmem.wr_en &&
		dmem.addr == $past(dmem.addr, 2)) else $error("write does not follow read");
	a_toggle_one: assert property (dmem.wr_en && !zero_set |->
		$countones(dmem.wdata ^ rd_ff) == 1) else $error("toggle changed wrong bits");
	a_clear_zero: assert property (zero_set |-> dmem.wr_en && dmem.wdata == CLEAR_VALUE)
		else $error("clear write wrong");
	a_wdt_flags: assert property (watchdog_clear |->
		timeout_flag_set && powerdown_flag_set ##1 !watchdog_clear) else $error("wdt pulses");
	a_flush_len: assert property ($rose(cycle_flushed) |->
		cycle_flushed[*4] ##1 !cycle_flushed) else $error("flush length wrong");
	a_flush_quiet: assert property (cycle_flushed |-> !(dmem.rd_en || dmem.wr_en ||
		stack_push || watchdog_clear || zero_set)) else $error("flushed word acted");
	a_flush_pc: assert property (cycle_flushed |=> $stable(prog_addr))
		else $error("pc moved in flush");
	a_push_ret: assert property (stack_push |->
		return_stack_top == prog_addr + CALL_RET_STEP ##2 cycle_flushed)
		else $error("return address wrong");
	a_fast_copy: assert property (stack_push && prog_word[BIT_FAST] |=>
		working_shadow == $past(working_reg) && status_shadow == $past(status_reg) &&
		bank_select_shadow == $past(bank_select_reg)) else $error("shadow copy wrong");
endmodule

bind cbbc_core cbbc_core_checker #(.ACCESS_SPLIT(ACCESS_SPLIT)) chk_u (
	.aclk, .aresetn, .prog_addr, .prog_word, .dmem, .dmem_rdata, .bank_select_reg,
	.working_reg, .status_reg, .zero_set, .working_shadow, .status_shadow,
	.bank_select_shadow, .stack_push, .return_stack_top, .watchdog_clear,
	.timeout_flag_set, .powerdown_flag_set, .cycle_flushed
);

// [testbench/cbbc_core_bench.sv]
`timescale 1ns/1ps
module cbbc_core_bench import cbbc_pkg::*; ;
	logic               aclk = 1'b0, aresetn = 1'b0;
	logic [AXI_A_W-1:0] awaddr = '0, araddr = '0;
	logic [AXI_D_W-1:0] wdata = '0, rdata;
	logic [3:0]         wstrb = '0, bank_select_reg = '0, bank_select_shadow;
	logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic               arvalid = 1'b0, rready = 1'b0;
	logic               overflow_flag = 1'b0, zero_flag = 1'b0;
	logic [7:0]         working_reg = '0, status_reg = '0, dmem_rdata;
	logic               awready, wready, bvalid, arready, rvalid, zero_set, stack_push;
	logic               watchdog_clear, timeout_flag_set, powerdown_flag_set, cycle_flushed;
	logic [1:0]         bresp, rresp;
	logic [PC_W-1:0]    prog_addr, return_stack_top;
	logic [15:0]        prog_word, prog_word_next;
	cbbc_dmem_s         dmem;
	logic [7:0]         working_shadow, status_shadow;
	logic [15:0]        pm [0:511];
	logic [7:0]         dm [0:4095];
	logic [PC_W-1:0]    ta [$];
	int                 tt [$];
	int                 cyc = 0, fails = 0, check_count = 0, zs_n, wd_n, sp_n;
	integer             seed = 32'h745b;

	cbbc_core dut_u (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .prog_addr, .prog_word, .prog_word_next, .dmem, .dmem_rdata,
		.bank_select_reg, .overflow_flag, .zero_flag, .working_reg, .status_reg, .zero_set,
		.working_shadow, .status_shadow, .bank_select_shadow, .stack_push, .return_stack_top,
		.watchdog_clear, .timeout_flag_set, .powerdown_flag_set, .cycle_flushed
	);

	always #25 aclk = ~aclk;
	// Memories alias on the low address bits so far call targets still hit code
	assign prog_word      = pm[prog_addr[9:1]];
	assign prog_word_next = pm[prog_addr[9:1] + 9'h001];
	assign dmem_rdata     = dm[dmem.addr];
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (aresetn) begin
			zs_n += zero_set;
			wd_n += watchdog_clear + timeout_flag_set + powerdown_flag_set;
			sp_n += stack_push;
			if (dmem.wr_en) dm[dmem.addr] <= dmem.wdata;
			if (ta.size() == 0 || prog_addr != ta[$]) begin
				ta.push_back(prog_addr);
				tt.push_back(cyc);
			end
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
			fails++;
		end
	endtask
	task automatic wrap_up;
		if (fails == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic hang;
		fails++;
		wrap_up();
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		repeat (100) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (bvalid !== 1'b1) hang();
		check(bresp, er);
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		repeat (100) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (rvalid !== 1'b1) hang();
		check(rresp, er);
		d = rdata;
		rready <= 1'b0;
	endtask
	function automatic logic [11:0] eaddr(input logic a, input logic [7:0] f, input logic [3:0] b);
		if (a) return {b, f};
		return {(f < ACC_SPLIT_DEF) ? ACC_LOW_BANK : ACC_HIGH_BANK, f};
	endfunction
	////////////////////////////////////////////////////////////////
	task automatic run_once(input logic [1:0] r);
		logic [2:0]      b0, b1;
		logic [3:0]      bs;
		logic [7:0]      f0, n1, n2, d0, d1, wr, sr, ua;
		logic [11:0]     hi, e0, e1, e2;
		logic            s, ca, ov, zf;
		logic [PC_W-1:0] a, t;
		logic [PC_W-1:0] eq [$];
		int              ed [$];
		logic [31:0]     pcv, rc, x;
		int              k;
		@(posedge aclk);
		aresetn <= 1'b0;
		@(posedge aclk);
		{b0, b1, bs, f0, hi} = 30'($random(seed));
		{wr, sr, ua} = 24'($random(seed));
		n1 = 8'($unsigned($random(seed)) % 26) + 8'd1;
		n2 = (r == 2'd0) ? 8'h80 : (r == 2'd1) ? 8'h7f : 8'($random(seed));
		if (n2 == 8'hff) n2 = 8'hfe;
		{s, ca, ov, zf} = {r[1], ~r[0], r[0], r[0] ^ r[1]};
		ua = {ua[7:2], 2'b00} | 8'h10;
		overflow_flag <= ov;
		zero_flag <= zf;
		bank_select_reg <= bs;
		working_reg <= wr;
		status_reg <= sr;
		for (k = 0; k < 512; k++) pm[k] = 16'hffff;
		for (k = 0; k < 4096; k++) dm[k] = 8'($random(seed));
		pm[0] = CODE_TOGGLE | {4'h0, b0, 1'b0, f0};
		pm[1] = CODE_TOGGLE | {4'h0, b1, 1'b1, f0 ^ 8'h01};
		pm[2] = CODE_CLEAR | {7'h00, ca, f0 ^ 8'h40};
		pm[3] = CODE_WDT;
		pm[4] = CODE_BOV | {8'h00, n1};
		pm[32] = CODE_CALL | {7'h00, s, 8'h80};
		pm[33] = {4'hf, hi};
		pm[{hi[0], 8'h80}] = CODE_BZ | {8'h00, n2};
		e0 = eaddr(1'b0, f0, bs);
		e1 = eaddr(1'b1, f0 ^ 8'h01, bs);
		e2 = eaddr(ca, f0 ^ 8'h40, bs);
		d0 = dm[e0];
		d1 = dm[e1];
		eq = {21'h0, 21'h2, 21'h4, 21'h6, 21'h8};
		ed = {4, 4, 4, 4, 4};
		a = ov ? 21'd10 + {n1, 1'b0} : 21'd10;
		k = ov ? 8 : 4;
		while (a < 21'h40) begin
			eq.push_back(a);
			ed.push_back(k);
			k = 4;
			a = a + 21'd2;
		end
		t = {hi, 8'h80, 1'b0};
		eq.push_back(21'h40);
		ed.push_back(4);
		eq.push_back(t);
		ed.push_back(8);
		eq.push_back(zf ? t + 21'd2 + {{12{n2[7]}}, n2, 1'b0} : t + 21'd2);
		repeat (11) @(posedge aclk);
		ta.delete();
		tt.delete();
		{zs_n, wd_n, sp_n} = '0;
		aresetn <= 1'b1;
		// Stop between instructions, then the count and pc must agree
		axw(REG_CTRL_OFS, 32'h0, RESP_OKAY);
		repeat (12) @(posedge aclk);
		axr(REG_PC_OFS, RESP_OKAY, pcv);
		axr(REG_RETIRE_OFS, RESP_OKAY, rc);
		check(pcv, rc << 1);
		axr(REG_INSTR_OFS, RESP_OKAY, x);
		check(x, {16'h0000, pm[0]});
		axr(REG_CTRL_OFS, RESP_OKAY, x);
		check(x, 32'h0);
		axr(ua, RESP_SLVERR, x);
		check(x, 32'h0);
		axw(ua, 32'h5a, RESP_SLVERR);
		axw(REG_PC_OFS, $random(seed), RESP_OKAY);
		axr(REG_PC_OFS, RESP_OKAY, x);
		check(x, pcv);
		axw(REG_CTRL_OFS, 32'h1, RESP_OKAY);
		for (k = 0; k < 3000 && ta.size() < eq.size(); k++) @(negedge aclk);
		if (ta.size() < eq.size()) hang();
		check(dm[e0], d0 ^ (8'h01 << b0));
		check(dm[e1], d1 ^ (8'h01 << b1));
		check(dm[e2], CLEAR_VALUE);
		check({zs_n[7:0], wd_n[7:0], sp_n[7:0]}, 24'h010301);
		check(return_stack_top, 21'h44);
		check({working_shadow, status_shadow, bank_select_shadow}, s ? {wr, sr, bs} : 20'h0);
		for (k = 0; k < 3000 && ta.size() <= eq.size(); k++) @(negedge aclk);
		if (ta.size() <= eq.size()) hang();
		for (k = 0; k < eq.size(); k++) begin
			check(ta[k], eq[k]);
			if (k >= 4 && k < ed.size()) check(tt[k + 1] - tt[k], ed[k]);
		end
	endtask

	initial begin
		for (int r = 0; r < 4; r++) begin
			run_once(2'(r));
		end
		wrap_up();
	end
endmodule
